// ==== shared/srpm_defs.svh ====
// Constants for the status register bank and event counter readout
`ifndef SRPM_DEFS_SVH
`define SRPM_DEFS_SVH
`define SRPM_NUM_SR        8
`define SRPM_NUM_CTR       32
`define SRPM_CTR_W         48
`define SRPM_LO_W          32
`define SRPM_HI_W          16
`define SRPM_SR_PSS        3'h0
`define SRPM_SR_UNDEF      3'h1
`define SRPM_SR_LOWCTR     3'h2
`define SRPM_SR_UPCTR      3'h3
`define SRPM_SR_MEF        3'h4
`define SRPM_SR_SYN        3'h5
`define SRPM_SR_LOC        3'h6
`define SRPM_SR_TPF        3'h7
`define SRPM_B_CLNZ        63
`define SRPM_B_BML         57
`define SRPM_B_BUSY        47
`define SRPM_B_UME         47
`define SRPM_B_CME         46
`define SRPM_B_RPE         47
`define SRPM_B_SHARED_REGISTER_READ_FAULT        46
`define SRPM_WR_MASK       64'h0000_0000_C01F_FBF6
`define SRPM_BUSY_CYC      3
`define SRPM_ZERO64        64'h0000_0000_0000_0000
`endif

// ==== shared/srpm_pkg.sv ====
// Types for the status register bank
package srpm_pkg;
  typedef logic [47:0] srpm_ctr_t;
  typedef logic [63:0] srpm_word_t;
  typedef enum logic [0:0] {SRPM_IDLE, SRPM_BUSY} srpm_rd_t;
  typedef struct packed {
    srpm_word_t pss;
    logic [13:0] mef_code;
    logic        uncorrectable_error_flag;
    logic        correctable_error_flag;
    logic [11:0] syn;
    logic [12:0] loc;
    logic [6:0]  tlb_miss;
    logic [6:0]  tlb_multi;
    logic        register_parity_fault;
    logic [11:0] rpe_chip;
    logic        shared_register_read_fault;
    logic [7:0]  shared_register_read_fault_chip;
    logic [3:0]  lo_sel;
    logic [3:0]  hi_sel;
    srpm_rd_t    rd;
    logic [1:0]  busy_cnt;
    srpm_word_t  rdata;
    logic [4:0]  rdest;
    logic        rvalid;
  } srpm_state_t;
endpackage : srpm_pkg

// ==== design/srpm_status_bank.sv ====
// Status register bank with event counter readout
// Contract
// - First counter read returns lower group 0-17, second upper group 20-37.
// - Counter read places full 48-bit value into destination scalar register.
// - Busy flag at bit 47 of register zero; issuer waits for clear.
// - Each counter is low slice bits 0-31 plus high slice 32-47.
// - Counters advance on their event only outside monitor mode.
// - Eight status registers read by index into a scalar register.
// - Status registers sit outside exchange package; switches never touch them.
// - Register zero: cluster nonzero 63, matrix loaded 57, cpu 40-46, cluster 32-39.
// - Only trap, memory mode, cache, fp flag, fp enable and rounding bits are writable.
// - Fp flags bits 16-11, enables bits 9-4, same order.
// - Rounding mode high at bit 2, low at bit 1.
// - Register one holds nothing meaningful.
// - Register two returns lower counter, register three upper counter, bits 0-47.
// - Upper readout maps bits 0-47 onto selected counter 20-37.
// - Memory error register keeps first error only; read clears it.
// - Error bit 47 uncorrectable, 46 correctable, 32-45 destination code.
// - Destination code top three bits select destination kind.
// - Register five holds syndrome in 32-43 until read.
// - Register six holds error address in 32-44 until read.
// - Register seven: table miss flags 48-54, multi-hit flags 55-61.
// - Register seven bit 47 parity error with chip number 32-43.
// - Register seven bit 46 shared read error with chip number 24-31.
// - Thirty-two event counters, each forty-eight bits wide.
`timescale 1ns/1ps
`default_nettype none
`include "srpm_defs.svh"
module srpm_status_bank
(
  input  wire logic        mclk_i,
  input  wire logic        resetn_i,
  input  wire logic        monitor_mode_i,
  input  wire logic [31:0] ctr_event_i,
  input  wire logic [11:0] ctr_step_i,
  input  wire logic        ctr_clear_i,
  input  wire logic        read_status_op_i,
  input  wire logic [2:0]  read_sel_i,
  input  wire logic [4:0]  read_dest_i,
  input  wire logic        write_status_op_i,
  input  wire logic [63:0] write_data_i,
  input  wire logic [7:0]  cluster_id_i,
  input  wire logic [6:0]  cpu_index_i,
  input  wire logic        bit_matrix_loaded_flag_i,
  input  wire logic        fp_flag_set_i,
  input  wire logic [5:0]  fp_flag_bits_i,
  input  wire logic        mem_err_i,
  input  wire logic        mem_err_uncorr_i,
  input  wire logic [13:0] mem_err_code_i,
  input  wire logic [11:0] mem_err_syn_i,
  input  wire logic [12:0] mem_err_addr_i,
  input  wire logic [6:0]  tlb_miss_i,
  input  wire logic [6:0]  tlb_multi_i,
  input  wire logic        rpe_i,
  input  wire logic [11:0] rpe_chip_i,
  input  wire logic        shared_register_read_fault_i,
  input  wire logic [7:0]  shared_register_read_fault_chip_i,
  output logic [63:0]      read_data_o,
  output logic [4:0]       read_dest_o,
  output logic             read_valid_o,
  output logic [63:0]      status_zero_o
);

  // Decode of destination code kind from top bits
  function automatic logic [2:0] srpm_dest_kind(input logic [13:0] code);
    srpm_dest_kind = code[13:11];
  endfunction : srpm_dest_kind

  // Counter value assembled from slices
  function automatic srpm_pkg::srpm_ctr_t srpm_join(input logic [15:0] hi,
                                                    input logic [31:0] lo);
    srpm_join = {hi, lo};
  endfunction : srpm_join

  // Counter slices kept in arrays
  logic [31:0] ctr_lo [0:31];
  logic [15:0] ctr_hi [0:31];
  logic [2:0]  last_kind;
  srpm_pkg::srpm_state_t st;
  srpm_pkg::srpm_state_t next_st;

  // Counter advance, only outside monitor mode
  always_ff @(posedge mclk_i)
  begin
    for (int i = 0; i < `SRPM_NUM_CTR; i++)
    begin
      if (!resetn_i || ctr_clear_i)
      begin
        ctr_lo[i] <= 32'h0000_0000;
        ctr_hi[i] <= 16'h0000;
      end
      else if (ctr_event_i[i] && !monitor_mode_i)
      begin
        {ctr_hi[i], ctr_lo[i]} <= srpm_join(ctr_hi[i], ctr_lo[i])
                                  + {36'h0_0000_0000, ctr_step_i};
      end
    end
  end

  // Next state: writes, captures, reads
  always_comb
  begin
    logic [4:0] idx;
    srpm_pkg::srpm_word_t w;
    idx = 5'h00;
    w = `SRPM_ZERO64;
    next_st = st;
    next_st.rvalid = 1'b0;
    // Fixed identity fields of register zero
    next_st.pss[`SRPM_B_CLNZ] = |cluster_id_i;
    next_st.pss[`SRPM_B_BML] = bit_matrix_loaded_flag_i;
    next_st.pss[46:40] = cpu_index_i;
    next_st.pss[39:32] = cluster_id_i;
    // Write only the writable fields
    if (write_status_op_i)
    begin
      next_st.pss = (next_st.pss & ~`SRPM_WR_MASK) | (write_data_i & `SRPM_WR_MASK);
    end
    if (fp_flag_set_i)
    begin
      next_st.pss[16:11] = next_st.pss[16:11] | fp_flag_bits_i;
    end
    // Busy window between counter reads
    unique case (st.rd)
      srpm_pkg::SRPM_IDLE: next_st.busy_cnt = 2'h0;
      srpm_pkg::SRPM_BUSY:
      begin
        next_st.busy_cnt = st.busy_cnt + 2'h1;
        if (st.busy_cnt == 2'(`SRPM_BUSY_CYC - 1))
          next_st.rd = srpm_pkg::SRPM_IDLE;
      end
    endcase
    // Fault flags in register seven, sticky until read
    next_st.tlb_miss = st.tlb_miss | tlb_miss_i;
    next_st.tlb_multi = st.tlb_multi | tlb_multi_i;
    // Status read: mux and read side effects
    if (read_status_op_i)
    begin
      unique case (read_sel_i)
        `SRPM_SR_PSS: w = st.pss;
        `SRPM_SR_UNDEF: w = `SRPM_ZERO64;
        `SRPM_SR_LOWCTR:
        begin
          idx = {1'b0, st.lo_sel};
          w = {16'h0000, srpm_join(ctr_hi[idx], ctr_lo[idx])};
          next_st.lo_sel = (st.lo_sel == 4'hF) ? 4'h0 : st.lo_sel + 4'h1;
          next_st.rd = srpm_pkg::SRPM_BUSY;
          next_st.busy_cnt = 2'h0;
        end
        `SRPM_SR_UPCTR:
        begin
          idx = {1'b1, st.hi_sel};
          w = {16'h0000, srpm_join(ctr_hi[idx], ctr_lo[idx])};
          next_st.hi_sel = (st.hi_sel == 4'hF) ? 4'h0 : st.hi_sel + 4'h1;
          next_st.rd = srpm_pkg::SRPM_BUSY;
          next_st.busy_cnt = 2'h0;
        end
        `SRPM_SR_MEF:
        begin
          w = {16'h0000, st.uncorrectable_error_flag, st.correctable_error_flag, st.mef_code, 32'h0000_0000};
          next_st.uncorrectable_error_flag = 1'b0;
          next_st.correctable_error_flag = 1'b0;
          next_st.mef_code = 14'h0000;
        end
        `SRPM_SR_SYN:
        begin
          w = {20'h0_0000, st.syn, 32'h0000_0000};
          next_st.syn = 12'h000;
        end
        `SRPM_SR_LOC:
        begin
          w = {19'h0_0000, st.loc, 32'h0000_0000};
          next_st.loc = 13'h0000;
        end
        `SRPM_SR_TPF:
        begin
          w = {2'h0, st.tlb_multi, st.tlb_miss, st.register_parity_fault, st.shared_register_read_fault, 2'h0,
               st.rpe_chip, st.shared_register_read_fault_chip, 24'h00_0000};
          next_st.tlb_miss = tlb_miss_i;
          next_st.tlb_multi = tlb_multi_i;
          next_st.register_parity_fault = 1'b0;
          next_st.shared_register_read_fault = 1'b0;
        end
      endcase
      next_st.rdata = w;
      next_st.rdest = read_dest_i;
      next_st.rvalid = 1'b1;
    end
    // First memory error capture; set wins over read clear
    if (mem_err_i && (!(st.uncorrectable_error_flag || st.correctable_error_flag) || (read_status_op_i && read_sel_i == `SRPM_SR_MEF)))
    begin
      next_st.uncorrectable_error_flag = mem_err_uncorr_i;
      next_st.correctable_error_flag = !mem_err_uncorr_i;
      next_st.mef_code = mem_err_code_i;
      next_st.syn = mem_err_syn_i;
      next_st.loc = mem_err_addr_i;
    end
    // Parity and shared read faults with chip number
    if (rpe_i && !next_st.register_parity_fault)
    begin
      next_st.register_parity_fault = 1'b1;
      next_st.rpe_chip = rpe_chip_i;
    end
    if (shared_register_read_fault_i && !next_st.shared_register_read_fault)
    begin
      next_st.shared_register_read_fault = 1'b1;
      next_st.shared_register_read_fault_chip = shared_register_read_fault_chip_i;
    end
    // Busy flag follows the read state it will have, so it shows the cycle after a read
    next_st.pss[`SRPM_B_BUSY] = (next_st.rd == srpm_pkg::SRPM_BUSY);
  end

  // Destination kind of the latest mem_err_i, captured or not, kept for debug visibility
  always_ff @(posedge mclk_i)
  begin
    if (!resetn_i)
      last_kind <= 3'h0;
    else if (mem_err_i)
      last_kind <= srpm_dest_kind(mem_err_code_i);
  end

  // State register
  always_ff @(posedge mclk_i)
  begin
    if (!resetn_i)
      st <= '0;
    else
      st <= next_st;
  end

  // Outputs straight from flops
  assign read_data_o = st.rdata;
  assign read_dest_o = st.rdest;
  assign read_valid_o = st.rvalid;
  assign status_zero_o = st.pss;

endmodule : srpm_status_bank
`default_nettype wire

// ==== bench/srpm_checker.sv ====
// Port assertions for the status register bank
`timescale 1ns/1ps
`default_nettype none
`include "srpm_defs.svh"
module srpm_checker (
  input wire logic        mclk_i,
  input wire logic        resetn_i,
  input wire logic        read_status_op_i,
  input wire logic [2:0]  read_sel_i,
  input wire logic [4:0]  read_dest_i,
  input wire logic        write_status_op_i,
  input wire logic [63:0] write_data_i,
  input wire logic        fp_flag_set_i,
  input wire logic [7:0]  cluster_id_i,
  input wire logic [6:0]  cpu_index_i,
  input wire logic [63:0] read_data_o,
  input wire logic [4:0]  read_dest_o,
  input wire logic        read_valid_o,
  input wire logic [63:0] status_zero_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  // Counter group read request
  wire logic ctr_rd = read_status_op_i && (read_sel_i[2:1] == 2'h1);
  // Busy high three cycles, then clear
  sequence busy_run;
    status_zero_o[47] [*3] ##1 !status_zero_o[47];
  endsequence
  AST_VALID: assert property (read_status_op_i |=> read_valid_o)
    else $error("read not answered");
  AST_NOVALID: assert property (!read_status_op_i |=> !read_valid_o)
    else $error("spurious read answer");
  AST_DEST: assert property (read_status_op_i |=> read_dest_o == $past(read_dest_i))
    else $error("wrong destination tag");
  AST_BUSY: assert property (ctr_rd |=> busy_run)
    else $error("busy flag timing wrong");
  AST_UNDEF: assert property (read_status_op_i && read_sel_i == 3'h1 |=> read_data_o == 64'h0)
    else $error("slot one not empty");
  AST_CTRHI: assert property (ctr_rd |=> read_data_o[63:48] == 16'h0)
    else $error("counter read upper bits set");
  AST_WRITE: assert property (write_status_op_i && !fp_flag_set_i |=>
    (status_zero_o & `SRPM_WR_MASK) == ($past(write_data_i) & `SRPM_WR_MASK))
    else $error("writable fields not loaded");
  AST_HOLD: assert property (!write_status_op_i && !fp_flag_set_i |=>
    status_zero_o[31:0] == $past(status_zero_o[31:0]))
    else $error("low fields changed without write");
  AST_IDENT: assert property ($past(resetn_i) |->
    status_zero_o[46:32] == $past({cpu_index_i, cluster_id_i}))
    else $error("identity fields wrong");
  AST_CLNZ: assert property (status_zero_o[63] == (status_zero_o[39:32] != 8'h00))
    else $error("cluster nonzero flag wrong");
endmodule : srpm_checker
`default_nettype wire

// ==== bench/srpm_issuer_model.sv ====
// Issue-side model spacing status reads and waiting on busy
`timescale 1ns/1ps
`default_nettype none
module srpm_issuer_model (
  input  wire logic       mclk_i,
  input  wire logic       busy_i,
  output var  logic       op_o,
  output var  logic [2:0] sel_o,
  output var  logic [4:0] dest_o
);
  logic [1:0] gap = 2'h3;
  // Clocks since the last taken read
  always @(posedge mclk_i) gap <= op_o ? 2'h0 : (gap == 2'h3 ? gap : gap + 2'h1);
  initial
  begin
    op_o = 1'b0;
    sel_o = 3'h0;
    dest_o = 5'h0;
  end
  // One read, held for one taking edge
  task automatic issue(input logic [2:0] s, input logic [4:0] d);
    while (busy_i || gap != 2'h3) @(negedge mclk_i);
    op_o = 1'b1;
    sel_o = s;
    dest_o = d;
    @(negedge mclk_i);
    op_o = 1'b0;
    sel_o = ~s;
    dest_o = ~d;
  endtask : issue
endmodule : srpm_issuer_model
`default_nettype wire

// ==== bench/srpm_status_bank_tb.sv ====
// Testbench for the status register bank
`timescale 1ns/1ps
`default_nettype none
`include "srpm_defs.svh"
module srpm_status_bank_tb;
  logic mclk_i = 1'b0, resetn_i = 1'b0, mon, fps, me, meu, register_parity_fault, shared_register_read_fault, wop, bit_matrix_loaded_flag, rv, op;
  logic [31:0] ev, rng = 32'h0000005E;
  logic [11:0] step, syn, rch;
  logic [13:0] code;
  logic [12:0] addr;
  logic [7:0]  cl, sch;
  logic [6:0]  cpu, miss, multi;
  logic [5:0]  fpb;
  logic [4:0]  rdest, dest;
  logic [2:0]  sel;
  logic [47:0] e0, e16;
  logic [63:0] wd, rd, st, x4, x5, x6, x7;
  int errors = 0, checked = 0, cyc = 0;
  // Clock and hang guard
  always #20 mclk_i = ~mclk_i;
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      errors++;
      final_report();
    end
  end
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : xs
  function automatic logic [63:0] ident();
    return {cl != 8'h00, 5'h0, bit_matrix_loaded_flag, 9'h0, 1'b0, cpu, cl, 32'h0};
  endfunction : ident
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic rdchk(input logic [2:0] s, input logic [63:0] exp);
    logic [4:0] d;
    void'(xs());
    d = rng[4:0];
    i_srpm_issuer_model.issue(s, d);
    chk({63'h0, rv}, 64'h1);
    chk({59'h0, rdest}, {59'h0, d});
    chk(rd, exp);
  endtask : rdchk
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report
  srpm_issuer_model i_srpm_issuer_model (.mclk_i, .busy_i(st[47]), .op_o(op), .sel_o(sel),
    .dest_o(dest));
  srpm_status_bank i_srpm_status_bank (.mclk_i, .resetn_i, .monitor_mode_i(mon),
    .ctr_event_i(ev), .ctr_step_i(step), .ctr_clear_i(1'b0),
    .read_status_op_i(op), .read_sel_i(sel), .read_dest_i(dest), .write_status_op_i(wop),
    .write_data_i(wd), .cluster_id_i(cl), .cpu_index_i(cpu), .bit_matrix_loaded_flag_i(bit_matrix_loaded_flag),
    .fp_flag_set_i(fps), .fp_flag_bits_i(fpb), .mem_err_i(me), .mem_err_uncorr_i(meu),
    .mem_err_code_i(code), .mem_err_syn_i(syn), .mem_err_addr_i(addr), .tlb_miss_i(miss),
    .tlb_multi_i(multi), .rpe_i(register_parity_fault), .rpe_chip_i(rch), .shared_register_read_fault_i(shared_register_read_fault), .shared_register_read_fault_chip_i(sch),
    .read_data_o(rd), .read_dest_o(rdest), .read_valid_o(rv), .status_zero_o(st));
  // Main sequence
  initial
  begin
    {mon, fps, me, meu, register_parity_fault, shared_register_read_fault, wop, bit_matrix_loaded_flag, ev, step, syn, rch, code, addr} = '0;
    {cl, sch, cpu, miss, multi, fpb, wd, e0, e16} = '0;
    repeat (5) @(negedge mclk_i);
    resetn_i = 1'b1;
    void'(xs());
    cl = rng[7:0] | 8'h01;
    cpu = rng[14:8];
    bit_matrix_loaded_flag = 1'b1;
    repeat (40)
    begin
      @(negedge mclk_i);
      void'(xs());
      ev = {15'h0, rng[1], 15'h0, rng[0]};
      step = rng[13:2];
      mon = rng[20];
      if (!mon)
      begin
        e0 += ev[0] ? step : 12'h0;
        e16 += ev[16] ? step : 12'h0;
      end
    end
    @(negedge mclk_i);
    ev = '0;
    rdchk(3'h2, {16'h0, e0});
    rdchk(3'h3, {16'h0, e16});
    $display("counter test done");
    repeat (4) @(negedge mclk_i);
    for (int i = 0; i < 2; i++)
    begin
      void'(xs());
      wop = 1'b1;
      wd = i ? {rng, ~rng} : '1;
      @(negedge mclk_i);
      wop = 1'b0;
      @(negedge mclk_i);
      chk(st, ident() | (wd & `SRPM_WR_MASK));
    end
    fps = 1'b1;
    fpb = 6'h2A;
    @(negedge mclk_i);
    fps = 1'b0;
    @(negedge mclk_i);
    chk(st, ident() | (wd & `SRPM_WR_MASK) | {47'h0, fpb, 11'h0});
    $display("status zero test done");
    void'(xs());
    {me, meu, register_parity_fault, shared_register_read_fault} = 4'hF;
    {code, syn, addr} = {rng[13:0], rng[25:14], rng[31:19]};
    {rch, sch, miss, multi} = {rng[11:0], rng[31:24], rng[6:0], rng[13:7]};
    x4 = {16'h0, 2'b10, code, 32'h0};
    x5 = {20'h0, syn, 32'h0};
    x6 = {19'h0, addr, 32'h0};
    x7 = {2'b0, multi, miss, 2'b11, 2'b0, rch, sch, 24'h0};
    @(negedge mclk_i);
    {meu, register_parity_fault, shared_register_read_fault, miss, multi} = '0;
    {code, syn, addr} = ~{code, syn, addr};
    @(negedge mclk_i);
    me = 1'b0;
    rdchk(3'h4, x4);
    rdchk(3'h5, x5);
    rdchk(3'h6, x6);
    rdchk(3'h7, x7);
    rdchk(3'h4, 64'h0);
    rdchk(3'h1, 64'h0);
    $display("error capture test done");
    final_report();
  end
endmodule : srpm_status_bank_tb
bind srpm_status_bank srpm_checker i_srpm_checker (.mclk_i, .resetn_i, .read_status_op_i,
  .read_sel_i, .read_dest_i, .write_status_op_i, .write_data_i, .fp_flag_set_i, .cluster_id_i,
  .cpu_index_i, .read_data_o, .read_dest_o, .read_valid_o, .status_zero_o);
`default_nettype wire
